// ===== shared/pcb_pkg.sv
// Shared constants and types for the position capture and brake block.
package pcb_pkg;

    // Parameter addresses as seen on the fieldbus parameter port.
    localparam logic [15:0] PAR_CAP_STATUS = 16'h0A02;
    localparam logic [15:0] PAR_U1_EDGE = 16'h0A04;
    localparam logic [15:0] PAR_U2_EDGE = 16'h0A06;
    localparam logic [15:0] PAR_U1_RUN = 16'h0A08;
    localparam logic [15:0] PAR_U2_RUN = 16'h0A0A;
    localparam logic [15:0] PAR_U1_POS = 16'h0A0C;
    localparam logic [15:0] PAR_U2_POS = 16'h0A0E;
    localparam logic [15:0] PAR_U1_TALLY = 16'h0A10;
    localparam logic [15:0] PAR_U2_TALLY = 16'h0A12;

    // Status word bit positions.
    localparam int STAT_U1_BIT = 0;
    localparam int STAT_U2_BIT = 1;

    // Run-control encodings.
    localparam logic [1:0] RUN_CANCEL = 2'h0;
    localparam logic [1:0] RUN_ONCE = 2'h1;
    localparam logic [1:0] RUN_CONT = 2'h2;

    // Edge-select encodings.
    localparam logic EDGE_FALL = 1'b0;
    localparam logic EDGE_RISE = 1'b1;

    // Error classes as presented by the drive's error handling.
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_CLASS2 = 3'h2;
    localparam logic [2:0] ERR_CLASS3 = 3'h3;
    localparam logic [2:0] ERR_CLASS4 = 3'h4;

    // Reset values.
    localparam logic [15:0] RST_16 = 16'h0000;
    localparam logic [31:0] RST_32 = 32'h0000_0000;

    // Brake timing at the 10 MHz reference clock.
    localparam int CLK_PERIOD_NS = 100;
    localparam int RELEASE_DELAY_NS = 100000;
    localparam int APPLY_DELAY_NS = 100000;
    localparam int RELEASE_DELAY_CYC =
        (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int APPLY_DELAY_CYC =
        (APPLY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 12;
    localparam logic [DLY_W-1:0] DLY_ZERO = 12'h000;

    // Number of pin inputs that pass the synchroniser.
    localparam int SYNC_W = 3;

    // Result of one capture unit.
    typedef struct packed {
        logic signed [31:0] pos;
        logic [15:0] tally;
        logic done;
    } pcb_cap_stat_t;

    // Power stage and brake sequencing states.
    typedef enum logic [3:0] {
        BRK_OFF = 4'h1,
        BRK_RELEASING = 4'h2,
        BRK_ENABLED = 4'h4,
        BRK_APPLYING = 4'h8
    } pcb_brk_state_t;

endpackage

// ===== verilog/pcb_capture_unit.sv
// One position capture unit: edge select, run control, tally and position.
`timescale 1ns/100ps
module pcb_capture_unit import pcb_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cap_level,
    input wire logic edge_rise,
    input wire logic run_wr,
    input wire logic [1:0] run_wdata,
    input wire logic signed [31:0] motor_position,
    input wire logic ref_shift,
    input wire logic signed [31:0] ref_delta,
    output logic [1:0] run_q,
    output pcb_cap_stat_t stat_q
);

    logic prev_q;
    logic qualify;
    logic cap_event;
    logic activate;

    // Edge qualification; the run write in the same cycle suppresses it.
    assign qualify = (edge_rise == EDGE_RISE) ? (cap_level & ~prev_q)
                                               : (~cap_level & prev_q);
    assign cap_event = qualify && (run_q != RUN_CANCEL) && !run_wr;
    assign activate = run_wr &&
        (run_wdata == RUN_ONCE || run_wdata == RUN_CONT);

    // Previous level of the synchronised input for edge detection.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= cap_level;
        end
    end

    // Run state; undefined codes are treated as cancel.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            run_q <= RUN_CANCEL;
        end else if (run_wr) begin
            run_q <= activate ? run_wdata : RUN_CANCEL;
        end else if (cap_event && run_q == RUN_ONCE) begin
            run_q <= RUN_CANCEL;
        end
    end

    // Tally, done flag and captured position.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stat_q <= '0;
        end else begin
            if (activate) begin
                stat_q.tally <= RST_16;
                stat_q.done <= 1'b0;
            end else if (cap_event) begin
                stat_q.tally <= stat_q.tally + 16'h0001;
                stat_q.done <= 1'b1;
            end
            if (cap_event) begin
                stat_q.pos <= motor_position;
            end else if (ref_shift) begin
                stat_q.pos <= stat_q.pos + ref_delta;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_armed_edge;
        qualify && run_q != RUN_CANCEL && !run_wr;
    endsequence

    property p_edge_sel;
        (cap_level && !prev_q && run_q != RUN_CANCEL && !run_wr)
            |-> (cap_event == (edge_rise == EDGE_RISE));
    endproperty
    a_edge_sel: assert property (p_edge_sel)
        else $error("Capture edge select not honoured.");

    property p_tally_inc;
        s_armed_edge |=> stat_q.tally == $past(stat_q.tally) + 16'h0001;
    endproperty
    a_tally_inc: assert property (p_tally_inc)
        else $error("Tally did not advance on a capture.");

    property p_arm_clear;
        activate |=> stat_q.tally == RST_16 && !stat_q.done;
    endproperty
    a_arm_clear: assert property (p_arm_clear)
        else $error("Activation did not clear tally and status.");

    property p_pos_latch;
        s_armed_edge |=> stat_q.pos == $past(motor_position) && stat_q.done;
    endproperty
    a_pos_latch: assert property (p_pos_latch)
        else $error("Position not latched on capture.");

    property p_single_disarm;
        (s_armed_edge and run_q == RUN_ONCE) |=> run_q == RUN_CANCEL;
    endproperty
    a_single_disarm: assert property (p_single_disarm)
        else $error("Single capture did not disarm.");

    property p_cont_stay;
        (run_q == RUN_CONT && !run_wr) |=> run_q == RUN_CONT;
    endproperty
    a_cont_stay: assert property (p_cont_stay)
        else $error("Continuous capture disarmed itself.");

    property p_rebase;
        (ref_shift && !cap_event) |=>
            stat_q.pos == $past(stat_q.pos) + $past(ref_delta);
    endproperty
    a_rebase: assert property (p_rebase)
        else $error("Captured position not rebased.");

endmodule

// ===== verilog/pcb_brake_seq.sv
// Holding brake and motor current sequencing against enable and errors.
`timescale 1ns/100ps
module pcb_brake_seq import pcb_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic enable_req,
    input wire logic [2:0] error_class,
    input wire logic sto_active,
    output logic brake_release_q,
    output logic current_on_q,
    output logic op_enabled_q
);

    pcb_brk_state_t st_q;
    pcb_brk_state_t st_d;
    logic [DLY_W-1:0] cnt_q;
    logic [DLY_W-1:0] cnt_d;
    logic err_hard;
    logic err_soft;

    assign err_hard = (error_class == ERR_CLASS3) ||
        (error_class == ERR_CLASS4);
    assign err_soft = (error_class == ERR_CLASS2);

    // Next state; hard errors and safe torque removal bypass the delay.
    always_comb begin
        st_d = st_q;
        cnt_d = (cnt_q != DLY_ZERO) ? cnt_q - 12'h001 : DLY_ZERO;
        case (st_q)
            BRK_OFF: begin
                if (enable_req && error_class == ERR_NONE && !sto_active) begin
                    st_d = BRK_RELEASING;
                    cnt_d = DLY_W'(RELEASE_DELAY_CYC - 1);
                end
            end
            BRK_RELEASING, BRK_ENABLED: begin
                if (err_hard || sto_active) begin
                    st_d = BRK_OFF;
                end else if (!enable_req || err_soft) begin
                    st_d = BRK_APPLYING;
                    cnt_d = DLY_W'(APPLY_DELAY_CYC - 1);
                end else if (st_q == BRK_RELEASING && cnt_q == DLY_ZERO) begin
                    st_d = BRK_ENABLED;
                end
            end
            BRK_APPLYING: begin
                if (err_hard || sto_active || cnt_q == DLY_ZERO) begin
                    st_d = BRK_OFF;
                end
            end
            default: begin
                st_d = BRK_OFF;
            end
        endcase
    end

    // State, delay counter and registered outputs.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= BRK_OFF;
            cnt_q <= DLY_ZERO;
            brake_release_q <= 1'b0;
            current_on_q <= 1'b0;
            op_enabled_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            brake_release_q <= (st_d == BRK_RELEASING) ||
                (st_d == BRK_ENABLED);
            current_on_q <= (st_d != BRK_OFF);
            op_enabled_q <= (st_d == BRK_ENABLED);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_hard_cut;
        ((st_q != BRK_OFF) && (err_hard || sto_active))
            |=> !current_on_q && !brake_release_q && st_q == BRK_OFF;
    endproperty
    a_hard_cut: assert property (p_hard_cut)
        else $error("Hard stop did not cut current at once.");

    property p_soft_hold;
        (st_q == BRK_APPLYING && cnt_q != DLY_ZERO && !err_hard && !sto_active)
            |=> current_on_q && !brake_release_q;
    endproperty
    a_soft_hold: assert property (p_soft_hold)
        else $error("Current dropped before the apply delay.");

    property p_soft_start;
        $rose(st_q == BRK_APPLYING) |->
            cnt_q == DLY_W'(APPLY_DELAY_CYC - 1) && !brake_release_q;
    endproperty
    a_soft_start: assert property (p_soft_start)
        else $error("Apply delay not loaded.");

    property p_release_wait;
        $rose(op_enabled_q) |->
            $past(st_q) == BRK_RELEASING && $past(cnt_q) == DLY_ZERO;
    endproperty
    a_release_wait: assert property (p_release_wait)
        else $error("Operation enabled before the release delay.");

endmodule

// ===== verilog/pcb_top.sv
// Two position capture units, their parameter port and the brake sequencer.
//
// Overview of operation
// - Unit one edge: 0 falling, 1 rising.
// - Unit two edge: 0 falling, 1 rising.
// - Read-only 16-bit tally counts each capture.
// - Activating unit one clears its tally.
// - Activating unit two clears its tally.
// - Qualifying edge latches signed 32-bit position.
// - Reference redefinition rebases stored captured positions.
// - Unit two run: 0 cancel, 1 once, 2 continuous.
// - Single mode disarms after first capture.
// - Continuous mode stays armed until cancelled.
// - Status bit 0 unit one, bit 1 unit two.
// - Enable releases brake, operation after delay.
// - Disable or class 2: brake, current delayed.
// - Class 3 or 4: brake, current off now.
// - Safe torque removal skips the brake delay.
// - Unit one run control: same encoding.
`timescale 1ns/100ps
module pcb_top import pcb_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic first_capture_input,
    input wire logic second_capture_input,
    input wire logic safe_torque_removal,
    input wire logic signed [31:0] motor_position,
    input wire logic ref_redefine,
    input wire logic signed [31:0] ref_delta,
    input wire logic enable_req,
    input wire logic [2:0] error_class,
    input wire logic [15:0] par_addr,
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_wdata,
    output logic [31:0] par_rdata,
    output logic par_ack,
    output logic par_err,
    output logic brake_release,
    output logic motor_current_on,
    output logic op_enabled
);

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic u1_edge_q;
    logic u2_edge_q;
    logic u1_run_wr;
    logic u2_run_wr;
    logic [1:0] u1_run;
    logic [1:0] u2_run;
    pcb_cap_stat_t u1_stat;
    pcb_cap_stat_t u2_stat;
    logic [15:0] status_word;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic addr_rw;
    logic [31:0] par_rdata_q;
    logic par_ack_q;
    logic par_err_q;

    // Pin inputs pass two flops; only the second rank is read by logic.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {safe_torque_removal, second_capture_input,
                        first_capture_input};
            sync2_q <= sync1_q;
        end
    end

    // Run-control writes are one-cycle strokes into the units.
    assign u1_run_wr = par_wr && (par_addr == PAR_U1_RUN);
    assign u2_run_wr = par_wr && (par_addr == PAR_U2_RUN);

    // Edge-select registers keep only their meaningful bit.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            u1_edge_q <= EDGE_FALL;
            u2_edge_q <= EDGE_FALL;
        end else if (par_wr) begin
            if (par_addr == PAR_U1_EDGE) begin
                u1_edge_q <= par_wdata[0];
            end
            if (par_addr == PAR_U2_EDGE) begin
                u2_edge_q <= par_wdata[0];
            end
        end
    end

    // First capture unit.
    pcb_capture_unit u_first_capture_input (
        .ref_clk(ref_clk),
        .reset(reset),
        .cap_level(sync2_q[0]),
        .edge_rise(u1_edge_q),
        .run_wr(u1_run_wr),
        .run_wdata(par_wdata[1:0]),
        .motor_position(motor_position),
        .ref_shift(ref_redefine),
        .ref_delta(ref_delta),
        .run_q(u1_run),
        .stat_q(u1_stat)
    );

    // Second capture unit.
    pcb_capture_unit u_second_capture_input (
        .ref_clk(ref_clk),
        .reset(reset),
        .cap_level(sync2_q[1]),
        .edge_rise(u2_edge_q),
        .run_wr(u2_run_wr),
        .run_wdata(par_wdata[1:0]),
        .motor_position(motor_position),
        .ref_shift(ref_redefine),
        .ref_delta(ref_delta),
        .run_q(u2_run),
        .stat_q(u2_stat)
    );

    // Brake sequencer; its outputs are flops inside the sequencer.
    pcb_brake_seq u_brake (
        .ref_clk(ref_clk),
        .reset(reset),
        .enable_req(enable_req),
        .error_class(error_class),
        .sto_active(sync2_q[2]),
        .brake_release_q(brake_release),
        .current_on_q(motor_current_on),
        .op_enabled_q(op_enabled)
    );

    // Shared status word; the unused bits read as zero.
    always_comb begin
        status_word = RST_16;
        status_word[STAT_U1_BIT] = u1_stat.done;
        status_word[STAT_U2_BIT] = u2_stat.done;
    end

    // Address decode and read selection.
    always_comb begin
        rd_mux = RST_32;
        addr_ok = 1'b1;
        addr_rw = 1'b0;
        case (par_addr)
            PAR_CAP_STATUS: rd_mux = {16'h0000, status_word};
            PAR_U1_EDGE: begin
                rd_mux = {31'h0000_0000, u1_edge_q};
                addr_rw = 1'b1;
            end
            PAR_U2_EDGE: begin
                rd_mux = {31'h0000_0000, u2_edge_q};
                addr_rw = 1'b1;
            end
            PAR_U1_RUN: begin
                rd_mux = {30'h0000_0000, u1_run};
                addr_rw = 1'b1;
            end
            PAR_U2_RUN: begin
                rd_mux = {30'h0000_0000, u2_run};
                addr_rw = 1'b1;
            end
            PAR_U1_POS: rd_mux = u1_stat.pos;
            PAR_U2_POS: rd_mux = u2_stat.pos;
            PAR_U1_TALLY: rd_mux = {16'h0000, u1_stat.tally};
            PAR_U2_TALLY: rd_mux = {16'h0000, u2_stat.tally};
            default: addr_ok = 1'b0;
        endcase
    end

    // Registered answer one cycle after each access; writes to read-only
    // parameters are refused like unknown addresses so software notices.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            par_rdata_q <= RST_32;
            par_ack_q <= 1'b0;
            par_err_q <= 1'b0;
        end else begin
            par_ack_q <= par_rd || par_wr;
            par_err_q <= (par_rd && !addr_ok) ||
                (par_wr && !(addr_ok && addr_rw));
            if (par_rd) begin
                par_rdata_q <= addr_ok ? rd_mux : RST_32;
            end
        end
    end

    assign par_rdata = par_rdata_q;
    assign par_ack = par_ack_q;
    assign par_err = par_err_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_status_bits;
        par_rd && par_addr == PAR_CAP_STATUS |=>
            par_rdata[1:0] == $past({u2_stat.done, u1_stat.done}) &&
            par_rdata[31:2] == 30'h0000_0000;
    endproperty
    a_status_bits: assert property (p_status_bits)
        else $error("Status word does not mirror the units.");

    property p_ro_tally;
        par_wr && par_addr == PAR_U1_TALLY |=> par_err && par_ack;
    endproperty
    a_ro_tally: assert property (p_ro_tally)
        else $error("Write to a read-only tally was not refused.");

    property p_run_encode;
        par_wr && par_addr == PAR_U2_RUN && par_wdata[1:0] == RUN_CONT
            |=> u2_run == RUN_CONT;
    endproperty
    a_run_encode: assert property (p_run_encode)
        else $error("Unit two did not arm for continuous capture.");

    property p_run_encode1;
        par_wr && par_addr == PAR_U1_RUN && par_wdata[1:0] == RUN_ONCE
            |=> u1_run == RUN_ONCE ##1
            (u1_run != RUN_CONT || $past(u1_run_wr));
    endproperty
    a_run_encode1: assert property (p_run_encode1)
        else $error("Unit one did not arm for single capture.");

    property p_sync_path;
        $rose(first_capture_input) ##1 first_capture_input
            |=> sync2_q[0];
    endproperty
    a_sync_path: assert property (p_sync_path)
        else $error("Capture input did not reach the second rank.");

    // Edge-select writes keep bit 0.
    property p_edge1_store;
        par_wr && par_addr == PAR_U1_EDGE |=>
            u1_edge_q == $past(par_wdata[0]);
    endproperty
    a_edge1_store: assert property (p_edge1_store)
        else $error("Unit one edge not stored.");

    property p_edge2_store;
        par_wr && par_addr == PAR_U2_EDGE |=>
            u2_edge_q == $past(par_wdata[0]);
    endproperty
    a_edge2_store: assert property (p_edge2_store)
        else $error("Unit two edge not stored.");

    // Read-only parameters refuse writes.
    property p_ro_tally2;
        par_wr && par_addr == PAR_U2_TALLY |=>
            par_err && par_ack;
    endproperty
    a_ro_tally2: assert property (p_ro_tally2)
        else $error("Tally write not refused.");

    property p_ro_pos;
        par_wr && (par_addr == PAR_U1_POS || par_addr == PAR_U2_POS)
            |=> par_err && par_ack;
    endproperty
    a_ro_pos: assert property (p_ro_pos)
        else $error("Position write not refused.");

    property p_ro_status;
        par_wr && par_addr == PAR_CAP_STATUS |=>
            par_err && par_ack;
    endproperty
    a_ro_status: assert property (p_ro_status)
        else $error("Status write not refused.");

    property p_run_cancel2;
        par_wr && par_addr == PAR_U2_RUN && par_wdata[1:0] == RUN_CANCEL
            |=> u2_run == RUN_CANCEL;
    endproperty
    a_run_cancel2: assert property (p_run_cancel2)
        else $error("Unit two did not cancel.");

    // Brake outputs at the pins; torque removal counts once synchronised.
    property p_op_released;
        op_enabled |->
            brake_release && motor_current_on;
    endproperty
    a_op_released: assert property (p_op_released)
        else $error("Operation with brake held.");

    property p_soft_stop;
        op_enabled && !enable_req && error_class == ERR_NONE && !sync2_q[2]
            |=> motor_current_on && !brake_release && !op_enabled;
    endproperty
    a_soft_stop: assert property (p_soft_stop)
        else $error("Disable did not hold current.");

    property p_class_cut;
        error_class == ERR_CLASS3 || error_class == ERR_CLASS4
            |=> !motor_current_on && !brake_release;
    endproperty
    a_class_cut: assert property (p_class_cut)
        else $error("Hard error left current on.");

    property p_sto_cut;
        sync2_q[2] |=>
            !motor_current_on && !brake_release;
    endproperty
    a_sto_cut: assert property (p_sto_cut)
        else $error("Torque removal left current on.");

endmodule

// ===== dv/pcb_far_side.sv
// Model of the capture signal sources and the motor holding brake.
`timescale 1ns/100ps
module pcb_far_side (
    input wire logic ref_clk,
    input wire logic [2:0] pin_req,
    input wire logic brake_release,
    output logic first_capture_input,
    output logic second_capture_input,
    output logic safe_torque_removal,
    output logic brake_held
);
    logic [2:0] req_q = 3'h0;

    // Requests are taken on the rising edge and launched on the falling
    // one, so every pin level stands for at least one whole cycle.
    always @(posedge ref_clk) begin
        req_q <= pin_req;
    end

    // Pin levels start low and follow the sampled requests.
    initial begin
        first_capture_input = 1'b0;
        second_capture_input = 1'b0;
        safe_torque_removal = 1'b0;
    end
    always @(negedge ref_clk) begin
        first_capture_input <= req_q[0];
        second_capture_input <= req_q[1];
        safe_torque_removal <= req_q[2];
    end

    // The brake closes whenever its coil is not driven to release.
    assign brake_held = !brake_release;
endmodule

// ===== dv/tb_top.sv
// Self-checking testbench for the position capture and brake block.
`timescale 1ns/100ps
module tb_top;
    import pcb_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] pin_req = 3'h0;
    logic signed [31:0] motor_position = 32'h0;
    logic ref_redefine = 1'b0;
    logic signed [31:0] ref_delta = 32'h0;
    logic enable_req = 1'b0;
    logic [2:0] error_class = 3'h0;
    logic [15:0] par_addr = 16'h0;
    logic par_wr = 1'b0;
    logic par_rd = 1'b0;
    logic [15:0] par_wdata = 16'h0;
    logic [31:0] par_rdata;
    logic par_ack, par_err, brake_release, motor_current_on, op_enabled;
    logic first_capture_input, second_capture_input, safe_torque_removal;
    logic brake_held;
    logic [31:0] rd_q;
    logic err_q;
    logic [15:0] addrs [9] = '{PAR_CAP_STATUS, PAR_U1_EDGE, PAR_U2_EDGE,
        PAR_U1_RUN, PAR_U2_RUN, PAR_U1_POS, PAR_U2_POS, PAR_U1_TALLY,
        PAR_U2_TALLY};
    int n_mismatch = 0;
    int checks_done = 0;
    int n;

    // Clock of 100 ns period.
    always #50 ref_clk = ~ref_clk;

    pcb_top u_dut (.ref_clk, .reset, .first_capture_input,
        .second_capture_input, .safe_torque_removal, .motor_position,
        .ref_redefine, .ref_delta, .enable_req, .error_class, .par_addr,
        .par_wr, .par_rd, .par_wdata, .par_rdata, .par_ack, .par_err,
        .brake_release, .motor_current_on, .op_enabled);

    pcb_far_side u_far (.ref_clk, .pin_req, .brake_release,
        .first_capture_input, .second_capture_input,
        .safe_torque_removal, .brake_held);

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One parameter access; the strobe is a one-cycle pulse by contract.
    task automatic access(input logic wr, input logic [15:0] a,
        input logic [15:0] d);
        int i;
        @(negedge ref_clk);
        par_addr = a;
        par_wdata = d;
        par_wr = wr;
        par_rd = !wr;
        @(negedge ref_clk);
        par_wr = 1'b0;
        par_rd = 1'b0;
        i = 0;
        while (par_ack !== 1'b1 && i < 4) begin
            @(negedge ref_clk);
            i++;
        end
        if (par_ack !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
        rd_q = par_rdata;
        err_q = par_err;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        access(1'b0, a, 16'h0);
        check(rd_q, exp);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    // Counts cycles until op_enabled (0) or motor current (1) reaches lvl.
    task automatic count_to(input int sel, input logic lvl, output int cnt);
        cnt = 0;
        while (((sel == 0) ? op_enabled : motor_current_on) !== lvl
            && cnt < 1200) begin
            @(negedge ref_clk);
            cnt++;
        end
        if (cnt >= 1200) begin
            n_mismatch++;
            final_report();
        end
    endtask

    // Main sequence.
    initial begin
        cyc(20);
        reset = 1'b0;
        // Every register reads zero after reset; a tally write and an unknown address are refused.
        foreach (addrs[i]) rd_chk(addrs[i], 32'h0);
        access(1'b1, PAR_U1_TALLY, 16'h5);
        check(err_q, 1'b1);
        rd_chk(PAR_U1_TALLY, 32'h0);
        access(1'b0, 16'h0A14, 16'h0);
        check(err_q, 1'b1);
        $display("test registers done");

        // Unit one, rising edge, single capture of a negative position.
        motor_position = 32'h8765_4321;
        access(1'b1, PAR_U1_EDGE, 16'h1);
        access(1'b1, PAR_U1_RUN, {14'h0, RUN_ONCE});
        pin_req[0] = 1'b1;
        cyc(8);
        rd_chk(PAR_U1_POS, 32'h8765_4321);
        rd_chk(PAR_U1_TALLY, 32'h1);
        rd_chk(PAR_CAP_STATUS, 32'h1);
        rd_chk(PAR_U1_RUN, 32'h0);
        motor_position = 32'h0000_0100;
        pin_req[0] = 1'b0;
        cyc(6);
        pin_req[0] = 1'b1;
        cyc(8);
        rd_chk(PAR_U1_TALLY, 32'h1);
        rd_chk(PAR_U1_POS, 32'h8765_4321);
        // Re-arm continuous on the falling edge: tally and status clear.
        access(1'b1, PAR_U1_EDGE, 16'h0);
        access(1'b1, PAR_U1_RUN, {14'h0, RUN_CONT});
        rd_chk(PAR_U1_TALLY, 32'h0);
        rd_chk(PAR_CAP_STATUS, 32'h0);
        pin_req[0] = 1'b0;
        cyc(8);
        rd_chk(PAR_U1_TALLY, 32'h1);
        $display("test unit one done");

        // Unit two, falling edge, continuous, then rebase and cancel.
        pin_req[1] = 1'b1;
        cyc(6);
        motor_position = 32'h0000_0200;
        access(1'b1, PAR_U2_EDGE, 16'h0);
        access(1'b1, PAR_U2_RUN, {14'h0, RUN_CONT});
        repeat (2) begin
            pin_req[1] = 1'b0;
            cyc(6);
            pin_req[1] = 1'b1;
            cyc(6);
        end
        rd_chk(PAR_U2_TALLY, 32'h2);
        rd_chk(PAR_U2_RUN, 32'h2);
        rd_chk(PAR_CAP_STATUS, 32'h3);
        @(negedge ref_clk);
        ref_redefine = 1'b1;
        ref_delta = 32'h0000_0010;
        @(negedge ref_clk);
        ref_redefine = 1'b0;
        rd_chk(PAR_U2_POS, 32'h0000_0210);
        rd_chk(PAR_U1_POS, 32'h0000_0110);
        access(1'b1, PAR_U2_RUN, {14'h0, RUN_CANCEL});
        pin_req[1] = 1'b0;
        cyc(8);
        rd_chk(PAR_U2_TALLY, 32'h2);
        access(1'b1, PAR_U2_RUN, {14'h0, RUN_ONCE});
        rd_chk(PAR_U2_TALLY, 32'h0);
        rd_chk(PAR_CAP_STATUS, 32'h1);
        access(1'b1, PAR_U1_RUN, {14'h0, RUN_CANCEL});
        rd_chk(PAR_U1_RUN, 32'h0);
        $display("test unit two done");

        // Brake: enable, then five ways of stopping the power stage.
        for (int k = 0; k < 5; k++) begin
            @(negedge ref_clk);
            enable_req = 1'b1;
            @(negedge ref_clk);
            check(brake_release, 1'b1);
            check(op_enabled, 1'b0);
            count_to(0, 1'b1, n);
            check(n, RELEASE_DELAY_CYC);
            if (k == 0) enable_req = 1'b0;
            if (k > 0 && k < 4) error_class = (k == 1) ? ERR_CLASS2 :
                ((k == 2) ? ERR_CLASS3 : ERR_CLASS4);
            if (k == 4) pin_req[2] = 1'b1;
            @(negedge ref_clk);
            if (k < 4) check(brake_release, 1'b0);
            count_to(1, 1'b0, n);
            if (k < 2) check(n, APPLY_DELAY_CYC);
            if (k == 2 || k == 3) check(n, 32'h0);
            if (k == 4) check(n < 8, 1'b1);
            check(brake_held, 1'b1);
            enable_req = 1'b0;
            error_class = ERR_NONE;
            pin_req[2] = 1'b0;
            cyc(10);
        end
        $display("test brake done");
        final_report();
    end
endmodule
